// ---- rtl/ufb_pkg.sv ----
/*
 Constants, field layouts and carrier types for the serial port format,
 bank select and extended mode control block.
 Assumes a single core clock and an 8-bit I/O-mapped host port.
*/
package ufb_pkg;

    // Host port offsets
    localparam logic [2:0] OFS_DATA      = 3'h0;
    localparam logic [2:0] OFS_FIFO_CTL  = 3'h2;
    localparam logic [2:0] OFS_EXT_CTL   = 3'h2;
    localparam logic [2:0] OFS_BANK      = 3'h3;
    localparam logic [2:0] OFS_MODE_CTL  = 3'h4;
    localparam logic [2:0] OFS_MODEM_ST  = 3'h6;
    localparam logic [2:0] OFS_AUX       = 3'h7;

    // Banks holding the control registers
    localparam logic [2:0] BANK_MAIN     = 3'h0;
    localparam logic [2:0] BANK_EXT      = 3'h2;

    // Reset values
    localparam logic [7:0] RST_BANK      = 8'h00;
    localparam logic [7:0] RST_MODE_CTL  = 8'h00;
    localparam logic [6:0] RST_LINE_FMT  = 7'h00;
    localparam logic [7:0] RST_EXT_CTL   = 8'h00;
    localparam logic [7:0] RST_AUX       = 8'h00;

    // Bank select fields
    localparam int BIT_BANK_SWITCH       = 7;

    // Mode control fields
    localparam int BIT_MODE_HI           = 7;
    localparam int BIT_MODE_LO           = 5;
    localparam int BIT_TX_DEFER          = 3;
    localparam int BIT_DMA_EN            = 2;
    localparam int BIT_RTS               = 1;
    localparam int BIT_DTR               = 0;
    localparam int BIT_ISEN              = 3;

    // Extended control one fields
    localparam int BIT_EXT_SWITCH        = 0;
    localparam int BIT_LOOP              = 4;

    // Fifo control fields
    localparam int BIT_FIFO_EN           = 0;

    // Operation modes
    typedef enum logic [2:0] {
        OPM_ASYNC    = 3'h0,
        OPM_ASK_IR   = 3'h2,
        OPM_SIR      = 3'h3,
        OPM_CONS_IR  = 3'h6
    } ufb_opmode_type;

    // Five parity kinds need a three-bit code
    typedef enum logic [2:0] {
        PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK_ONE, PAR_SPACE_ZERO
    } ufb_parity_type;

    // Line format byte, bit 6 unused by the format logic
    typedef struct packed {
        logic       spare;
        logic       forced_parity;
        logic       even_parity_pick;
        logic       parity_on;
        logic       stop_bit_count_select;
        logic [1:0] char_length_select;
    } ufb_line_fmt_type;

    typedef struct packed {
        logic [3:0]     data_bits;
        logic [2:0]     tx_stop_halves;
        logic [1:0]     rx_stop_bits;
        ufb_parity_type parity_kind;
    } ufb_frame_type;

    typedef struct packed {
        logic [2:0] bank;
        logic       reserved;
    } ufb_bank_type;

endpackage : ufb_pkg

// ---- rtl/ufb_bank_decode.sv ----
/*
 Bank number decode from the bank select byte.
 Assumes the byte comes straight from the bank select register.
*/
module ufb_bank_decode
    import ufb_pkg::*;
(
    input  wire logic [7:0]   bank_number,
    output ufb_bank_type      decoded
);

    function automatic ufb_bank_type ufb_bank_of(input logic [7:0] v);
        ufb_bank_type r;
        r = '{bank: 3'h0, reserved: 1'b0};
        if (!v[BIT_BANK_SWITCH]) begin
            r.bank = 3'h0;
        end else if (!v[6] || v[1] || v[0]) begin
            r.bank = 3'h1;
        end else if (v[5] && !(v[4] && v[3])) begin
            r.bank = 3'(3'h2 + {1'b0, v[4:3], 1'b0} + {2'b00, v[2]});
        end else begin
            r.reserved = 1'b1;
        end
        return r;
    endfunction : ufb_bank_of

    // Reserved patterns give bank 0 with reserved set and reach no bank registers; bank select stays reachable
    assign decoded = ufb_bank_of(bank_number);

endmodule : ufb_bank_decode

// ---- rtl/ufb_frame_format.sv ----
/*
 Character framing decode from the line format byte plus parity bit
 generation for one outgoing character.
 Assumes the character is right-aligned with unused high bits ignored.
*/
module ufb_frame_format
    import ufb_pkg::*;
(
    input  ufb_line_fmt_type fmt,
    input  wire logic [7:0]  char_data,
    output ufb_frame_type    frame,
    output logic             parity_bit
);

    logic [7:0] masked;

    always_comb begin
        frame.data_bits = 4'(4'h5 + {2'b00, fmt.char_length_select});
        // Half-bit units so 1.5 stop bits stay exact
        if (!fmt.stop_bit_count_select) begin
            frame.tx_stop_halves = 3'h2;
        end else if (fmt.char_length_select == 2'b00) begin
            frame.tx_stop_halves = 3'h3;
        end else begin
            frame.tx_stop_halves = 3'h4;
        end
        frame.rx_stop_bits = 2'h1;
        case ({fmt.parity_on, fmt.forced_parity, fmt.even_parity_pick})
            3'b100:  frame.parity_kind = PAR_ODD;
            3'b101:  frame.parity_kind = PAR_EVEN;
            3'b110:  frame.parity_kind = PAR_MARK_ONE;
            3'b111:  frame.parity_kind = PAR_SPACE_ZERO;
            default: frame.parity_kind = PAR_NONE;
        endcase
        masked = char_data & 8'(8'hFF >> (4'h8 - frame.data_bits));
        case (frame.parity_kind)
            PAR_ODD:      parity_bit = ~(^masked);
            PAR_EVEN:     parity_bit = ^masked;
            PAR_MARK_ONE: parity_bit = 1'b1;
            default:      parity_bit = 1'b0;
        endcase
    end

endmodule : ufb_frame_format

// ---- rtl/ufb_ctrl.sv ----
/*
 Format, bank select and extended mode control registers of the serial
 port, reached over the 8-bit I/O host port, with the decoded controls.
 Assumes host strobes are one-cycle pulses synchronous to CLK and that
 FIFOs, status and the line engines live outside and obey the pulses.
*/
//
// Overview of operation
// - Stop select clear: one stop bit per transmitted character, reset default.
// - Stop select set: 1.5 stop bits for 5-bit, 2 otherwise.
// - Receiver checks only one stop bit regardless of stop select.
// - Length field 00..11 gives five to eight data bits; five at reset.
// - Parity none, odd, even, constant one or zero from three selects.
// - Bank select at offset 03h, reset 00h, steers later host accesses.
// - Bank switch enable clear forces bank 0; set lets low bits choose.
// - Bank 1 on 10xxxxxx, or 11 with bit 1 or bit 0 set.
// - Patterns E0 to F4 in steps of 4 pick banks 2 to 7.
// - Bank select identical and reachable from every bank.
// - Mode control at offset 04h, reset 00h, meaning depends on extended mode.
// - Extended mode: interrupt always enabled, loopback from extended control bit 4.
// - Extended mode field: 000 async, 010 ASK IR, 011 SIR, 110 consumer IR.
// - Mode field change flushes FIFOs, clears status interrupts and aux register.
// - Transmit deferral acts only while transmit FIFO enabled; resets off.
// - DMA enable routes DMA cycles to data holding regardless of bank.
// - Extended loopback: request-to-send drives CTS and DCD internally.
// - Extended loopback: terminal-ready drives DSR and RI internally.
// - Offset 03h acts as line format with bit 7 clear, bank select if set.
module ufb_ctrl
    import ufb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [2:0]  ADDR,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic [7:0]  WDATA,
    input  wire logic        DMA_ACK,
    input  wire logic [7:0]  TX_CHAR,
    input  wire logic [3:0]  MODEM_IN,
    output logic [7:0]       RDATA,
    output logic [2:0]       BANK,
    output logic             BANK_RESERVED,
    output ufb_frame_type    FRAME,
    output logic             TX_PARITY,
    output logic             EXT_MODE,
    output ufb_opmode_type   OP_MODE,
    output logic             IRQ_ENABLE,
    output logic             TX_DEFER,
    output logic             DMA_ENABLE,
    output logic             HOLD_WR,
    output logic             HOLD_RD,
    output logic [3:0]       MODEM_STATUS,
    output logic             FLUSH_TX,
    output logic             FLUSH_RX,
    output logic             CLR_LINE_INT,
    output logic             CLR_MODEM_INT,
    output logic [7:0]       AUX
);

    typedef struct packed {
        logic [7:0]       bank_number;
        ufb_line_fmt_type line_fmt;
        logic [7:0]       mode_ctl;
        logic [7:0]       ext_ctl;
        logic             fifo_en;
        logic [7:0]       aux;
        logic [7:0]       rdata;
        logic             tx_parity;
        logic             mode_changed;
        logic             hold_wr;
        logic             hold_rd;
    } ufb_state_type;

    ufb_state_type    st;
    ufb_state_type    next_st;
    ufb_bank_type     dec;
    ufb_frame_type    frame;
    logic             parity_bit;
    logic             ext;
    logic             loop_on;
    logic [3:0]       modem_now;
    logic             dma_cycle;
    logic             acc_main;
    logic             acc_ext;

    ufb_bank_decode u_bank (
        .bank_number (st.bank_number),
        .decoded     (dec)
    );

    ufb_frame_format u_fmt (
        .fmt        (st.line_fmt),
        .char_data  (TX_CHAR),
        .frame      (frame),
        .parity_bit (parity_bit)
    );

    assign ext       = st.ext_ctl[BIT_EXT_SWITCH];
    assign loop_on   = ext && st.ext_ctl[BIT_LOOP];
    // Bit 2 means something else outside extended mode, so DMA needs ext too
    assign dma_cycle = DMA_ACK && ext && st.mode_ctl[BIT_DMA_EN];
    assign acc_main  = !dma_cycle && dec.bank == BANK_MAIN && !dec.reserved;
    assign acc_ext   = !dma_cycle && dec.bank == BANK_EXT && !dec.reserved;

    // Modem status order: DCD, RI, DSR, CTS
    always_comb begin
        if (loop_on) begin
            modem_now = {st.mode_ctl[BIT_RTS], st.mode_ctl[BIT_DTR],
                         st.mode_ctl[BIT_DTR], st.mode_ctl[BIT_RTS]};
        end else begin
            modem_now = MODEM_IN;
        end
    end

    always_comb begin
        next_st              = st;
        next_st.mode_changed = 1'b0;
        next_st.hold_wr      = 1'b0;
        next_st.hold_rd      = 1'b0;
        next_st.tx_parity    = parity_bit;
        if (WR) begin
            if (dma_cycle) begin
                next_st.hold_wr = 1'b1;
            end else if (ADDR == OFS_BANK) begin
                next_st.bank_number = WDATA;
                if (!WDATA[BIT_BANK_SWITCH]) begin
                    next_st.line_fmt = ufb_line_fmt_type'(WDATA[6:0]);
                end
            end else if (acc_main) begin
                case (ADDR)
                    OFS_DATA: begin
                        next_st.hold_wr = 1'b1;
                    end
                    OFS_FIFO_CTL: begin
                        next_st.fifo_en = WDATA[BIT_FIFO_EN];
                    end
                    OFS_MODE_CTL: begin
                        next_st.mode_ctl = WDATA;
                        if (ext && WDATA[BIT_MODE_HI:BIT_MODE_LO]
                                != st.mode_ctl[BIT_MODE_HI:BIT_MODE_LO]) begin
                            next_st.mode_changed = 1'b1;
                        end
                    end
                    OFS_AUX: begin
                        next_st.aux = WDATA;
                    end
                    default: begin
                    end
                endcase
            end else if (acc_ext && ADDR == OFS_EXT_CTL) begin
                next_st.ext_ctl = WDATA;
            end
        end
        // Mode change wipes aux one cycle later, after any same-cycle write
        if (st.mode_changed) begin
            next_st.aux = RST_AUX;
        end
        if (RD) begin
            next_st.rdata = 8'h00;
            if (dma_cycle) begin
                next_st.hold_rd = 1'b1;
            end else if (ADDR == OFS_BANK) begin
                next_st.rdata = st.bank_number;
            end else if (acc_main) begin
                case (ADDR)
                    OFS_DATA:     next_st.hold_rd = 1'b1;
                    OFS_FIFO_CTL: next_st.rdata = {7'h00, st.fifo_en};
                    OFS_MODE_CTL: next_st.rdata = st.mode_ctl;
                    OFS_MODEM_ST: next_st.rdata = {modem_now, 4'h0};
                    OFS_AUX:      next_st.rdata = st.aux;
                    default:      next_st.rdata = 8'h00;
                endcase
            end else if (acc_ext && ADDR == OFS_EXT_CTL) begin
                next_st.rdata = st.ext_ctl;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st <= '{bank_number: RST_BANK,
                    line_fmt: ufb_line_fmt_type'(RST_LINE_FMT),
                    mode_ctl: RST_MODE_CTL,
                    ext_ctl: RST_EXT_CTL, fifo_en: 1'b0, aux: RST_AUX,
                    rdata: 8'h00, tx_parity: 1'b0, mode_changed: 1'b0,
                    hold_wr: 1'b0, hold_rd: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign RDATA         = st.rdata;
    assign BANK          = dec.bank;
    assign BANK_RESERVED = dec.reserved;
    assign FRAME         = frame;
    assign TX_PARITY     = st.tx_parity;
    assign EXT_MODE      = ext;
    // Reserved mode codes pass through; the line engines treat them as async
    assign OP_MODE       = ext ? ufb_opmode_type'(st.mode_ctl[BIT_MODE_HI:BIT_MODE_LO])
                               : OPM_ASYNC;
    assign IRQ_ENABLE    = ext || st.mode_ctl[BIT_ISEN];
    assign TX_DEFER      = ext && st.mode_ctl[BIT_TX_DEFER] && st.fifo_en;
    assign DMA_ENABLE    = ext && st.mode_ctl[BIT_DMA_EN];
    assign HOLD_WR       = st.hold_wr;
    assign HOLD_RD       = st.hold_rd;
    assign MODEM_STATUS  = modem_now;
    assign FLUSH_TX      = st.mode_changed;
    assign FLUSH_RX      = st.mode_changed;
    assign CLR_LINE_INT  = st.mode_changed;
    assign CLR_MODEM_INT = st.mode_changed;
    assign AUX           = st.aux;

    property p_stop_one;
        @(posedge CLK) disable iff (!RST_N)
        !st.line_fmt.stop_bit_count_select |-> FRAME.tx_stop_halves == 3'h2;
    endproperty
    a_stop_one: assert property (p_stop_one) else $error("stop not one");

    property p_stop_long;
        @(posedge CLK) disable iff (!RST_N)
        st.line_fmt.stop_bit_count_select |->
            FRAME.tx_stop_halves == ((st.line_fmt.char_length_select == 2'b00) ? 3'h3 : 3'h4);
    endproperty
    a_stop_long: assert property (p_stop_long) else $error("long stop wrong");

    property p_rx_stop;
        @(posedge CLK) disable iff (!RST_N) FRAME.rx_stop_bits == 2'h1;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("rx stop not one");

    property p_len;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && !WDATA[7] && WDATA[1:0] == 2'b11
            |=> FRAME.data_bits == 4'h8;
    endproperty
    a_len: assert property (p_len) else $error("length not eight");

    property p_parity;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && WDATA[7:3] == 5'b00111
            |=> FRAME.parity_kind == PAR_SPACE_ZERO ##1 TX_PARITY == 1'b0;
    endproperty
    a_parity: assert property (p_parity) else $error("stick zero wrong");

    property p_bank_rb;
        @(posedge CLK) disable iff (!RST_N)
        WR && ADDR == OFS_BANK ##1 RD && ADDR == OFS_BANK && !DMA_ACK
            |=> RDATA == $past(WDATA, 2);
    endproperty
    a_bank_rb: assert property (p_bank_rb) else $error("bank readback");

    property p_bank0;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && !WDATA[7] |=> BANK == 3'h0 && !BANK_RESERVED;
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank not zero");

    property p_bank_hi;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && WDATA == 8'hF4 |=> BANK == 3'h7;
    endproperty
    a_bank_hi: assert property (p_bank_hi) else $error("bank seven");

    property p_mode_flush;
        @(posedge CLK) disable iff (!RST_N)
        WR && ADDR == OFS_MODE_CTL && acc_main && ext
            && WDATA[7:5] != st.mode_ctl[7:5]
            |=> FLUSH_TX && FLUSH_RX && CLR_LINE_INT ##1 !FLUSH_TX && AUX == 8'h00;
    endproperty
    a_mode_flush: assert property (p_mode_flush) else $error("no flush");

    property p_defer;
        @(posedge CLK) disable iff (!RST_N) TX_DEFER |-> st.fifo_en && EXT_MODE;
    endproperty
    a_defer: assert property (p_defer) else $error("defer without fifo");

    property p_dma;
        @(posedge CLK) disable iff (!RST_N)
        DMA_ACK && DMA_ENABLE && WR |=> HOLD_WR ##1 !HOLD_WR || $past(WR);
    endproperty
    a_dma: assert property (p_dma) else $error("dma not routed");

    property p_loop;
        @(posedge CLK) disable iff (!RST_N)
        loop_on |-> MODEM_STATUS == {st.mode_ctl[1], st.mode_ctl[0],
                                     st.mode_ctl[0], st.mode_ctl[1]};
    endproperty
    a_loop: assert property (p_loop) else $error("loop routing");

    property p_loop_dtr;
        @(posedge CLK) disable iff (!RST_N)
        loop_on |-> MODEM_STATUS[2:1] == {2{st.mode_ctl[BIT_DTR]}};
    endproperty
    a_loop_dtr: assert property (p_loop_dtr) else $error("loop dtr routing");

    property p_dma_rd;
        @(posedge CLK) disable iff (!RST_N)
        DMA_ACK && DMA_ENABLE && RD |=> HOLD_RD;
    endproperty
    a_dma_rd: assert property (p_dma_rd) else $error("dma read not routed");

    property p_irq;
        @(posedge CLK) disable iff (!RST_N) EXT_MODE |-> IRQ_ENABLE;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not forced on");

    property p_bank1;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && WDATA[7:6] == 2'b10
            |=> BANK == 3'h1 && !BANK_RESERVED;
    endproperty
    a_bank1: assert property (p_bank1) else $error("bank not one");

    property p_bank_rsv;
        @(posedge CLK) disable iff (!RST_N)
        WR && !DMA_ACK && ADDR == OFS_BANK && WDATA[7:5] == 3'b110 && WDATA[1:0] == 2'b00
            |=> BANK_RESERVED;
    endproperty
    a_bank_rsv: assert property (p_bank_rsv) else $error("reserved bank missed");

endmodule : ufb_ctrl

// ---- tb/ufb_modem_model.sv ----
/*
 Far-side model: the remote device's modem status lines.
 Assumes the bench's CLK and RST_N; lines move every cycle after reset.
*/
module ufb_modem_model
    import ufb_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST_N,
    output logic [3:0] MODEM_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] next_level;
    // Lines never rest, so a stale or looped path shows up at once
    always_comb next_level = MODEM_IN + 4'h5;
    always_ff @(posedge CLK) begin
        if (!RST_N)
            MODEM_IN <= 4'hA;
        else
            MODEM_IN <= next_level;
    end
endmodule : ufb_modem_model

// ---- tb/tb_top.sv ----
/*
 Self-checking bench for the format, bank select and mode control block.
 Assumes one core clock; all host accesses are one-cycle strobes.
*/
module tb_top
    import ufb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           CLK = 1'b0;
    logic           RST_N = 1'b0;
    logic [2:0]     ADDR = 3'h0;
    logic           WR = 1'b0;
    logic           RD = 1'b0;
    logic [7:0]     WDATA = 8'h00;
    logic           DMA_ACK = 1'b0;
    logic [7:0]     TX_CHAR = 8'h07;
    logic [3:0]     MODEM_IN;
    logic [7:0]     RDATA;
    logic [2:0]     BANK;
    logic           BANK_RESERVED;
    ufb_frame_type  FRAME;
    logic           TX_PARITY;
    logic           EXT_MODE;
    ufb_opmode_type OP_MODE;
    logic           IRQ_ENABLE;
    logic           TX_DEFER;
    logic           DMA_ENABLE;
    logic           HOLD_WR;
    logic           HOLD_RD;
    logic [3:0]     MODEM_STATUS;
    logic           FLUSH_TX;
    logic           FLUSH_RX;
    logic           CLR_LINE_INT;
    logic           CLR_MODEM_INT;
    logic [7:0]     AUX;
    int             failures = 0;
    int             checked = 0;
    int             cycles = 0;
    logic [7:0]     bv [14] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC1, 8'hC2, 8'hE0,
                                8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'hF8, 8'hC0};
    logic [3:0]     be [14] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2,
                                4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8};
    logic [2:0]     md [4] = '{3'h2, 3'h3, 3'h6, 3'h0};
    logic [2:0]     pk [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic           pb [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    ufb_modem_model far (.CLK(CLK), .RST_N(RST_N), .MODEM_IN(MODEM_IN));

    ufb_ctrl dut (
        .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA),
        .DMA_ACK(DMA_ACK), .TX_CHAR(TX_CHAR), .MODEM_IN(MODEM_IN), .RDATA(RDATA),
        .BANK(BANK), .BANK_RESERVED(BANK_RESERVED), .FRAME(FRAME),
        .TX_PARITY(TX_PARITY), .EXT_MODE(EXT_MODE), .OP_MODE(OP_MODE),
        .IRQ_ENABLE(IRQ_ENABLE), .TX_DEFER(TX_DEFER), .DMA_ENABLE(DMA_ENABLE),
        .HOLD_WR(HOLD_WR), .HOLD_RD(HOLD_RD), .MODEM_STATUS(MODEM_STATUS),
        .FLUSH_TX(FLUSH_TX), .FLUSH_RX(FLUSH_RX), .CLR_LINE_INT(CLR_LINE_INT),
        .CLR_MODEM_INT(CLR_MODEM_INT), .AUX(AUX)
    );

    initial begin
        forever #4 CLK = ~CLK;
    end

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One host access; strobes drop at the sampling edge, results settle 1 ns later
    task automatic acc(input logic w, input logic dm, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= w;
        RD <= ~w;
        DMA_ACK <= dm;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b0;
        DMA_ACK <= 1'b0;
        #1;
    endtask : acc

    // Write then read in the very next cycle; the read must see the new byte
    task automatic wr_then_rd(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
    endtask : wr_then_rd

    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        acc(0, 0, 3'h3, 8'h00);
        chk("bank_select", 8'h00, RDATA);
        acc(0, 0, 3'h4, 8'h00);
        chk("mode_ctl", 8'h00, RDATA);
        chk("data_bits", 8'h05, 8'(FRAME.data_bits));
        chk("stop_halves", 8'h02, 8'(FRAME.tx_stop_halves));
        chk("parity_kind", 8'h00, 8'(FRAME.parity_kind));
        acc(0, 0, 3'h1, 8'h00);
        chk("unmapped", 8'h00, RDATA);
        for (int i = 0; i < 8; i++) begin
            acc(1, 0, 3'h3, {5'h0, i[0], i[2:1]});
            chk("data_bits", 8'(5 + i[2:1]), 8'(FRAME.data_bits));
            chk("stop_halves", !i[0] ? 8'h02 : (i[2:1] == 0 ? 8'h03 : 8'h04),
                8'(FRAME.tx_stop_halves));
            chk("rx_stop", 8'h01, 8'(FRAME.rx_stop_bits));
        end
        for (int p = 0; p < 4; p++) begin
            acc(1, 0, 3'h3, {2'h0, p[1], p[0], 1'b1, 3'h3});
            @(posedge CLK);
            #1;
            chk("parity_kind", 8'(pk[p]), 8'(FRAME.parity_kind));
            chk("tx_parity", 8'(pb[p]), 8'(TX_PARITY));
        end
        for (int i = 0; i < 14; i++) begin
            acc(1, 0, 3'h3, bv[i]);
            chk("bank_reserved", 8'(be[i][3]), 8'(BANK_RESERVED));
            if (!be[i][3])
                chk("bank", 8'(be[i][2:0]), 8'(BANK));
            acc(0, 0, 3'h3, 8'h00);
            chk("bank_select", bv[i], RDATA);
        end
        acc(0, 0, 3'h4, 8'h00);
        chk("mode_ctl reserved bank", 8'h00, RDATA);
        chk("format kept", 8'h04, 8'(FRAME.parity_kind));
        acc(1, 0, 3'h3, 8'hE0);
        acc(1, 0, 3'h2, 8'h11);
        chk("ext_mode", 8'h01, 8'(EXT_MODE));
        chk("irq_enable", 8'h01, 8'(IRQ_ENABLE));
        acc(0, 0, 3'h3, 8'h00);
        chk("bank_select bank2", 8'hE0, RDATA);
        wr_then_rd(3'h3, 8'hE8);
        chk("bank_select back to back", 8'hE8, RDATA);
        chk("bank back to back", 8'h04, 8'(BANK));
        acc(1, 0, 3'h3, 8'h00);
        // Bits 7:2 cleared so the mode field stays 000; loopback on from extended control bit 4
        acc(1, 0, 3'h4, 8'h02);
        chk("flush no change", 8'h00, 8'(FLUSH_TX));
        chk("loop rts", 8'h09, 8'(MODEM_STATUS));
        acc(1, 0, 3'h4, 8'h01);
        chk("loop dtr", 8'h06, 8'(MODEM_STATUS));
        for (int m = 0; m < 4; m++) begin
            acc(1, 0, 3'h7, 8'h5A);
            chk("aux", 8'h5A, AUX);
            acc(1, 0, 3'h4, {md[m], 5'h0});
            chk("flush_tx", 8'h01, 8'(FLUSH_TX));
            chk("flush_rx", 8'h01, 8'(FLUSH_RX));
            chk("clr_line", 8'h01, 8'(CLR_LINE_INT));
            chk("clr_modem", 8'h01, 8'(CLR_MODEM_INT));
            chk("op_mode", 8'(md[m]), 8'(OP_MODE));
            @(posedge CLK);
            #1;
            chk("flush pulse", 8'h00, 8'(FLUSH_TX));
            chk("aux cleared", 8'h00, AUX);
        end
        acc(1, 0, 3'h4, 8'h08);
        chk("defer fifo off", 8'h00, 8'(TX_DEFER));
        acc(1, 0, 3'h2, 8'h01);
        chk("defer fifo on", 8'h01, 8'(TX_DEFER));
        // DMA enable set with deferral kept on; interrupts stay forced on in extended mode
        acc(1, 0, 3'h4, 8'h0C);
        chk("dma_enable", 8'h01, 8'(DMA_ENABLE));
        acc(1, 0, 3'h3, 8'hE0);
        acc(1, 0, 3'h0, 8'h55);
        chk("hold_wr plain", 8'h00, 8'(HOLD_WR));
        acc(1, 1, 3'h0, 8'h55);
        chk("hold_wr dma", 8'h01, 8'(HOLD_WR));
        acc(0, 1, 3'h5, 8'h00);
        chk("hold_rd dma", 8'h01, 8'(HOLD_RD));
        acc(1, 0, 3'h2, 8'h01);
        chk("no loop", 8'(MODEM_IN), 8'(MODEM_STATUS));
        final_report();
    end
endmodule : tb_top
